// file: macstl_regs.svh
// Behaviour
// - Dependent accumulate on register or pair zero after one gap adds one cycle.
// - Penalty applies to integer add and subtract variants, never to float ones.
// - Accumulator operand is the value the product is added to or subtracted from.
// - Penalty only when one bubble or one non-writing instruction separates them.
// - No penalty with two or more instructions, or one writing instruction, between.
// - Penalty recurs on every pass of a loop, never absorbed after the first.
// - Accumulators on any other data register or pair incur no extra cycle.
`ifndef MACSTL_REGS_SVH
`define MACSTL_REGS_SVH
`define MACSTL_REG_W 4
`define MACSTL_ZERO_REG 4'h0
`define MACSTL_PAIR_MASK 4'he
`define MACSTL_EXTRA_CYC 2'h1
`define MACSTL_GAP_ONE 2'h1
`define MACSTL_GAP_FAR 2'h2
`define MACSTL_HIST_DEPTH 3
`endif

// file: macstl_pkg.sv
package macstl_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_OTHER,
    OP_INT_MUL,
    OP_MADD_INT,
    OP_MSUB_INT,
    OP_MADD_FLT,
    OP_MSUB_FLT
  } macstl_op_e;
  typedef enum {ST_RUN, ST_HOLD} macstl_state_e;
endpackage

// file: macstl_hist.sv
`timescale 1ns/100ps
`default_nettype none
`include "macstl_regs.svh"
// Small history of producing instructions in issue slots
module macstl_hist (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift,
  input wire logic wr_prod,
  input wire logic [3:0] wr_dest,
  input wire logic wr_pair,
  input wire logic wr_any,
  output logic [`MACSTL_HIST_DEPTH-1:0] rd_prod,
  output logic [`MACSTL_HIST_DEPTH*4-1:0] rd_dest,
  output logic [`MACSTL_HIST_DEPTH-1:0] rd_pair,
  output logic [`MACSTL_HIST_DEPTH-1:0] rd_any
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_prod <= '0;
      rd_dest <= '0;
      rd_pair <= '0;
      rd_any <= '0;
    end else if (shift) begin
      rd_prod <= {rd_prod[`MACSTL_HIST_DEPTH-2:0], wr_prod};
      rd_dest <= {rd_dest[`MACSTL_HIST_DEPTH*4-5:0], wr_dest};
      rd_pair <= {rd_pair[`MACSTL_HIST_DEPTH-2:0], wr_pair};
      rd_any <= {rd_any[`MACSTL_HIST_DEPTH-2:0], wr_any};
    end
  end
endmodule // macstl_hist
`default_nettype wire

// file: macstl_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "macstl_regs.svh"
module macstl_top
  import macstl_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic ISSUE_VALID,
  input wire macstl_op_e ISSUE_OP,
  input wire logic [3:0] ISSUE_DEST,
  input wire logic ISSUE_DEST_PAIR,
  input wire logic ISSUE_WRITES,
  input wire logic [3:0] ISSUE_ACC,
  input wire logic ISSUE_ACC_PAIR,
  input wire logic NORMAL_STALL,
  output logic ISSUE_READY,
  output logic EXTRA_STALL,
  output logic [31:0] PENALTY_COUNT
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Integer multiply-add or multiply-subtract
  function automatic logic is_int_mac(input macstl_op_e op);
    begin
      is_int_mac = (op == OP_MADD_INT) || (op == OP_MSUB_INT);
    end
  endfunction
  // Float accumulate variants
  function automatic logic is_flt_mac(input macstl_op_e op);
    begin
      is_flt_mac = (op == OP_MADD_FLT) || (op == OP_MSUB_FLT);
    end
  endfunction
  // Integer multiply or integer accumulate
  function automatic logic is_producer(input macstl_op_e op);
    begin
      is_producer = (op == OP_INT_MUL) || is_int_mac(op);
    end
  endfunction
  // Register zero, or pair zero
  function automatic logic is_zero(input logic [3:0] r, input logic pair);
    begin
      if (pair) begin
        is_zero = ((r & `MACSTL_PAIR_MASK) == `MACSTL_ZERO_REG);
      end else begin
        is_zero = (r == `MACSTL_ZERO_REG);
      end
    end
  endfunction
  // Register or pair overlap
  function automatic logic same_reg(input logic [3:0] a, input logic ap,
                                    input logic [3:0] b, input logic bp);
    begin
      same_reg = ((a & `MACSTL_PAIR_MASK) == (b & `MACSTL_PAIR_MASK)) &&
                 (ap || bp || (a == b));
    end
  endfunction
  // Slot that is a bubble or a non-writer
  function automatic logic slot_gap(input logic prod, input logic any);
    begin
      slot_gap = !prod && !any;
    end
  endfunction
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  macstl_state_e state_r;
  macstl_state_e state_nxt;
  logic [1:0] hold_cnt_r;
  logic [1:0] hold_cnt_nxt;
  logic slot_adv;
  logic [`MACSTL_HIST_DEPTH-1:0] h_prod;
  logic [`MACSTL_HIST_DEPTH*4-1:0] h_dest;
  logic [`MACSTL_HIST_DEPTH-1:0] h_pair;
  logic [`MACSTL_HIST_DEPTH-1:0] h_any;
  logic issued;
  logic producer;
  logic writer;
  logic hazard;
  logic acc_zero;
  logic gap_one;
  logic dep_hit;
  logic mac_now;
  logic prev_prod;
  logic prev_any;
  logic far_prod;
  logic far_pair;
  logic [3:0] far_dest;
  // ----------------------------------------------------------------
  // Issue qualify
  // ----------------------------------------------------------------
  assign issued = ISSUE_VALID && ISSUE_READY && !NORMAL_STALL;
  assign producer = issued && is_producer(ISSUE_OP);
  assign writer = issued && ISSUE_WRITES;
  // Float variants never count as accumulate here
  assign mac_now = issued && is_int_mac(ISSUE_OP) && !is_flt_mac(ISSUE_OP);
  // ----------------------------------------------------------------
  // Issue slot history
  // ----------------------------------------------------------------
  // Every running cycle is a slot; empty slots are bubbles
  assign slot_adv = (state_r == ST_RUN);
  macstl_hist u_hist (
    .clk(CLK_SYS),
    .rst(RST),
    .shift(slot_adv),
    .wr_prod(producer),
    .wr_dest(ISSUE_DEST),
    .wr_pair(ISSUE_DEST_PAIR),
    .wr_any(writer),
    .rd_prod(h_prod),
    .rd_dest(h_dest),
    .rd_pair(h_pair),
    .rd_any(h_any)
  );
  // ----------------------------------------------------------------
  // History taps
  // ----------------------------------------------------------------
  assign prev_prod = h_prod[0];
  assign prev_any = h_any[0];
  assign far_prod = h_prod[1];
  assign far_pair = h_pair[1];
  assign far_dest = h_dest[7:4];
  // ----------------------------------------------------------------
  // Hazard detect
  // ----------------------------------------------------------------
  // Accumulator is the added-to or subtracted-from operand
  assign acc_zero = is_zero(ISSUE_ACC, ISSUE_ACC_PAIR);
  // Slot one back holds bubble or non-writer, slot two back is producer
  assign gap_one = slot_gap(prev_prod, prev_any) && far_prod;
  assign dep_hit = same_reg(far_dest, far_pair, ISSUE_ACC, ISSUE_ACC_PAIR);
  // Only in a running cycle; the accumulate is taken, then one cycle added
  assign hazard = slot_adv && mac_now && acc_zero && gap_one && dep_hit;
  // ----------------------------------------------------------------
  // Stall next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      ST_RUN: begin
        // No memory of past passes: each loop pass is judged afresh
        if (hazard) begin
          state_nxt = ST_HOLD;
          hold_cnt_nxt = `MACSTL_EXTRA_CYC;
        end
      end
      ST_HOLD: begin
        if (hold_cnt_r <= 2'h1) begin
          state_nxt = ST_RUN;
          hold_cnt_nxt = 2'h0;
        end else begin
          hold_cnt_nxt = hold_cnt_r - 2'h1;
        end
      end
      default: begin
        state_nxt = ST_RUN;
        hold_cnt_nxt = 2'h0;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Stall state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      hold_cnt_r <= 2'h0;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Issue outputs
  // ----------------------------------------------------------------
  // Operands untouched: only the next issue is held back
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ISSUE_READY <= 1'b1;
    end else begin
      ISSUE_READY <= (state_nxt == ST_RUN);
    end
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      EXTRA_STALL <= 1'b0;
    end else begin
      EXTRA_STALL <= (state_nxt == ST_HOLD);
    end
  end
  // ----------------------------------------------------------------
  // Penalty counter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PENALTY_COUNT <= 32'h0;
    end else if (hazard) begin
      PENALTY_COUNT <= PENALTY_COUNT + 32'h1;
    end
  end
endmodule // macstl_top
`default_nettype wire

// file: macstl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Stall checker
// ----
module macstl_asserts
  import macstl_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic ISSUE_VALID,
  input wire macstl_op_e ISSUE_OP,
  input wire logic [3:0] ISSUE_DEST,
  input wire logic ISSUE_DEST_PAIR,
  input wire logic ISSUE_WRITES,
  input wire logic [3:0] ISSUE_ACC,
  input wire logic ISSUE_ACC_PAIR,
  input wire logic NORMAL_STALL,
  input wire logic ISSUE_READY,
  input wire logic EXTRA_STALL,
  input wire logic [31:0] PENALTY_COUNT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire logic tk = ISSUE_VALID && ISSUE_READY && !NORMAL_STALL;
  property p_one; EXTRA_STALL |=> !EXTRA_STALL; endproperty
  a_one: assert property (p_one) else $error("stall too long");
  property p_rdy; ISSUE_READY == !EXTRA_STALL; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not tied to stall");
  property p_cnt; PENALTY_COUNT - $past(PENALTY_COUNT) == 32'(EXTRA_STALL); endproperty
  a_cnt: assert property (p_cnt) else $error("count step wrong");
  property p_flt; ISSUE_VALID && ISSUE_OP inside {OP_MADD_FLT, OP_MSUB_FLT} |=> !EXTRA_STALL; endproperty
  a_flt: assert property (p_flt) else $error("float stalled");
  property p_nmac; ISSUE_OP inside {OP_NONE, OP_OTHER, OP_INT_MUL} |=> !EXTRA_STALL; endproperty
  a_nmac: assert property (p_nmac) else $error("non accumulate stalled");
  property p_idle; !ISSUE_VALID |=> !EXTRA_STALL; endproperty
  a_idle: assert property (p_idle) else $error("idle stalled");
  property p_wgap; tk && ISSUE_WRITES ##1 1'b1 |=> !EXTRA_STALL; endproperty
  a_wgap: assert property (p_wgap) else $error("stall after writer");
  property p_acc;
    ISSUE_VALID && (ISSUE_ACC_PAIR ? ISSUE_ACC[3:1] != 3'h0 : ISSUE_ACC != 4'h0)
      |=> !EXTRA_STALL;
  endproperty
  a_acc: assert property (p_acc) else $error("other register stalled");
  property p_hit;
    (tk && ISSUE_OP inside {OP_INT_MUL, OP_MADD_INT, OP_MSUB_INT} && ISSUE_DEST_PAIR &&
      ISSUE_DEST[3:1] == 3'h0) ##1
    (ISSUE_READY && (!tk || !ISSUE_WRITES) &&
      !(tk && ISSUE_OP inside {OP_INT_MUL, OP_MADD_INT, OP_MSUB_INT})) ##1
    (tk && ISSUE_OP inside {OP_MADD_INT, OP_MSUB_INT} && ISSUE_ACC[3:1] == 3'h0 &&
      (ISSUE_ACC_PAIR || ISSUE_ACC == 4'h0)) |=> EXTRA_STALL;
  endproperty
  a_hit: assert property (p_hit) else $error("missing extra stall");
  c_hit: cover property (EXTRA_STALL);
  c_flt: cover property (ISSUE_VALID && ISSUE_OP == OP_MSUB_FLT);
  c_two: cover property (tk && ISSUE_OP == OP_OTHER ##1 tk && ISSUE_OP == OP_OTHER);
endmodule // macstl_asserts
bind macstl_top macstl_asserts i_chk (.*);
`default_nettype wire

// file: macstl_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Stall bench
// ----
module macstl_top_tb;
  import macstl_pkg::*;
  logic clk = 0, rst = 1, vld = 0, wr = 0, ap = 0, rdy, xs;
  macstl_op_e op = OP_NONE;
  logic [3:0] acc = 4'h0;
  logic [3:0] dst = 4'h0;
  logic dp = 1, ns = 0;
  logic [31:0] cnt;
  int fail_count = 0, comparisons = 0;
  macstl_top i_dut (.CLK_SYS(clk), .RST(rst), .ISSUE_VALID(vld), .ISSUE_OP(op),
    .ISSUE_DEST(dst), .ISSUE_DEST_PAIR(dp), .ISSUE_WRITES(wr), .ISSUE_ACC(acc),
    .ISSUE_ACC_PAIR(ap), .NORMAL_STALL(ns), .ISSUE_READY(rdy), .EXTRA_STALL(xs),
    .PENALTY_COUNT(cnt));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic put(macstl_op_e o, logic w, logic v, logic [3:0] a, logic p);
    @(negedge clk);
    {vld, wr, ap} = {v, w, p};
    op = o;
    acc = a;
  endtask
  task automatic seq(macstl_op_e pr, g, logic gw, int n, macstl_op_e m, logic [3:0] a,
    logic p, logic e);
    logic [31:0] c;
    c = cnt;
    put(pr, 1, 1, 4'h0, 1);
    repeat (n) put(g, gw, 1, 4'h0, 1);
    put(m, 1, 1, a, p);
    @(negedge clk);
    chk(32'(xs), 32'(e));
    chk(32'(rdy), 32'(!e));
    repeat (3) put(OP_NONE, 0, 0, 4'h0, 0);
    chk(cnt, c + 32'(e));
  endtask
  task automatic t_hit;
    for (int i = 0; i < 8; i++) begin
      seq(i[0] ? OP_MADD_INT : OP_INT_MUL, i[2] ? OP_OTHER : OP_NONE, 0, 1,
        i[1] ? OP_MSUB_INT : OP_MADD_INT, 4'h0, i[0], 1);
    end
    seq(OP_INT_MUL, OP_NONE, 0, 1, OP_MADD_INT, 4'h1, 1, 1);
  endtask
  task automatic t_ns;
    logic [31:0] c;
    c = cnt;
    put(OP_INT_MUL, 1, 1, 4'h0, 1);
    put(OP_MADD_INT, 1, 1, 4'h0, 1);
    ns = 1;
    @(negedge clk);
    ns = 0;
    @(negedge clk);
    chk(32'(xs), 32'h1);
    repeat (3) put(OP_NONE, 0, 0, 4'h0, 0);
    chk(cnt, c + 32'h1);
  endtask
  task automatic t_rst;
    rst = 1;
    @(negedge clk);
    chk(cnt, 32'h0);
    chk(32'(rdy), 32'h1);
    chk(32'(xs), 32'h0);
    rst = 0;
  endtask
  task automatic t_miss;
    seq(OP_INT_MUL, OP_NONE, 0, 1, OP_MADD_FLT, 4'h0, 1, 0);
    seq(OP_INT_MUL, OP_NONE, 0, 1, OP_MSUB_FLT, 4'h0, 1, 0);
    seq(OP_INT_MUL, OP_OTHER, 1, 1, OP_MADD_INT, 4'h0, 1, 0);
    seq(OP_INT_MUL, OP_OTHER, 0, 2, OP_MSUB_INT, 4'h0, 1, 0);
    seq(OP_INT_MUL, OP_NONE, 0, 0, OP_MADD_INT, 4'h0, 1, 0);
    seq(OP_MADD_INT, OP_NONE, 0, 1, OP_MADD_INT, 4'h2, 1, 0);
    seq(OP_INT_MUL, OP_NONE, 0, 1, OP_MSUB_INT, 4'h1, 0, 0);
    dst = 4'h6;
    seq(OP_INT_MUL, OP_NONE, 0, 1, OP_MADD_INT, 4'h0, 1, 0);
    dst = 4'h0;
  endtask
  task end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_hit();
    t_ns();
    t_miss();
    t_rst();
    seq(OP_INT_MUL, OP_NONE, 0, 1, OP_MADD_INT, 4'h0, 1, 1);
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule // macstl_top_tb
`default_nettype wire
